// File: core/timer_match_capture_pkg.sv
// Register map, field positions and reset values of the match/capture unit.
package timer_match_capture_pkg;

  localparam int unsigned NUM_MATCH   = 4;
  localparam int unsigned NUM_CAPTURE = 3;

  // Byte offsets on the register bus.
  localparam logic [7:0] OFS_IRQ_FLAGS     = 8'h00;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h04;
  localparam logic [7:0] OFS_TIMER_COUNT   = 8'h08;
  localparam logic [7:0] OFS_PRESCALE_MAX  = 8'h0C;
  localparam logic [7:0] OFS_PRESCALE_CNT  = 8'h10;
  localparam logic [7:0] OFS_MATCH_CTRL    = 8'h14;
  localparam logic [7:0] OFS_MATCH_VALUE_0 = 8'h18;
  localparam logic [7:0] OFS_MATCH_VALUE_3 = 8'h24;
  localparam logic [7:0] OFS_CAPTURE_CTRL  = 8'h28;
  localparam logic [7:0] OFS_CAPTURED_0    = 8'h2C;
  localparam logic [7:0] OFS_CAPTURED_2    = 8'h34;
  localparam logic [7:0] OFS_SHADOW_0      = 8'h40;
  localparam logic [7:0] OFS_SHADOW_3      = 8'h4C;
  localparam logic [7:0] OFS_CAPTURE_SRC   = 8'h50;

  // Timer control fields.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_RESET_BIT  = 1;

  // Match control fields: three action bits per channel, reloads above.
  localparam int unsigned ACT_BITS_PER_CH = 3;
  localparam int unsigned ACT_IRQ_OFS     = 0;
  localparam int unsigned ACT_RESET_OFS   = 1;
  localparam int unsigned ACT_STOP_OFS    = 2;
  localparam int unsigned ACT_RELOAD_LSB  = 24;
  localparam logic [31:0] ACT_WRITE_MASK  = 32'h0F00_0FFF;

  // Capture control fields: three bits per channel.
  localparam int unsigned EDGE_BITS_PER_CH = 3;
  localparam int unsigned EDGE_RISE_OFS    = 0;
  localparam int unsigned EDGE_FALL_OFS    = 1;
  localparam int unsigned EDGE_IRQ_OFS     = 2;
  localparam logic [31:0] EDGE_WRITE_MASK  = 32'h0000_01FF;

  // Interrupt flag layout.
  localparam int unsigned IRQ_CAPTURE_LSB = 4;
  localparam logic [31:0] IRQ_FLAG_MASK   = 32'h0000_007F;

  localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;

  // AHB transfer type bit that marks an active transfer.
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;

endpackage : timer_match_capture_pkg

// File: core/capture_edge_detect.sv
// Source selection, synchroniser and edge detector of one capture input.
`timescale 1ns/100ps
module capture_edge_detect (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Inputs
  input  wire logic pin_in,
  input  wire logic internal_in,
  input  wire logic use_internal,
  input  wire logic rise_enable,
  input  wire logic fall_enable,
  // Event
  output logic      capture_event
);
  logic sel_in;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic rose;
  logic fell;

  assign sel_in = use_internal ? internal_in : pin_in;

  // The first stage is read only by the second one.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= sel_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rose = sync2_reg & ~prev_reg;
  assign fell = ~sync2_reg & prev_reg;
  // Both enables together give an event on every edge.
  assign capture_event = (rise_enable & rose) | (fall_enable & fell);

endmodule : capture_edge_detect

// File: core/timer_match_capture_unit.sv
// Counter/timer with four match channels and three capture channels.
//
// Operation
// - Match 3 with stop halts counters, clears enable.
// - Enabled channels reload shadow when count clears.
// - Reload happens on the clearing edge itself.
// - Every match value compared to count continuously.
// - Match performs only the selected actions.
// - Software counter reset also triggers reloads.
// - Four match values at 0x018..0x024, reset zero.
// - Rising enable captures count on rising edge.
// - Falling enable captures count on falling edge.
// - Both enables capture on every edge.
// - Capture interrupt enable flags each capture load.
// - Capture input selectable from pin or internal.
// - Three capture values at 0x02C..0x034, reset zero.
// - Match interrupts set flag bits 0 to 3.
// - Capture interrupts set flag bits 4 to 6.
// - Channels 0 to 2 actions in bits 0..8.
// - Counter reset bit holds counters at zero.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
module timer_match_capture_unit
  import timer_match_capture_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = 32
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Capture inputs
  input  wire logic [timer_match_capture_pkg::NUM_CAPTURE-1:0] capture_pin,
  input  wire logic [timer_match_capture_pkg::NUM_CAPTURE-1:0] capture_internal
);
  import timer_match_capture_pkg::*;

  typedef logic [COUNT_WIDTH-1:0] count_t;

  // Register state.
  logic [6:0]             irq_flags_reg;
  logic [1:0]             timer_control_reg;
  count_t                 timer_count_reg;
  count_t                 prescale_max_reg;
  count_t                 prescale_count_reg;
  logic [31:0]            match_action_control_reg;
  count_t                 match_value_reg  [NUM_MATCH];
  count_t                 shadow_value_reg [NUM_MATCH];
  logic [8:0]             capture_edge_control_reg;
  count_t                 captured_count_reg [NUM_CAPTURE];
  logic [NUM_CAPTURE-1:0] capture_source_reg;
  logic [NUM_MATCH-1:0]   match_prev_reg;

  // Bus data-phase state.
  logic                   wr_pending_reg;
  logic [7:0]             wr_addr_reg;
  logic [31:0]            hrdata_reg;

  // Decode.
  logic                   addr_phase;
  logic                   rd_take;
  logic [7:0]             rd_addr;
  logic                   wr_irq;
  logic                   wr_ctrl;
  logic                   wr_count;
  logic                   wr_pr;
  logic                   wr_pcount;
  logic                   wr_act;
  logic                   wr_edge;
  logic                   wr_src;
  logic [NUM_MATCH-1:0]   wr_match;
  logic [NUM_MATCH-1:0]   wr_shadow;

  // Timer behaviour.
  logic                   counter_enable;
  logic                   counter_reset;
  logic                   prescale_tick;
  logic [NUM_MATCH-1:0]   match_hit;
  logic [NUM_MATCH-1:0]   match_new;
  logic [NUM_MATCH-1:0]   match_irq_set;
  logic [NUM_MATCH-1:0]   match_reset_req;
  logic [NUM_MATCH-1:0]   match_stop_req;
  logic [NUM_MATCH-1:0]   reload_enable;
  logic                   any_reset;
  logic                   any_stop;
  logic                   count_clear;
  logic [NUM_CAPTURE-1:0] capture_event;
  logic [NUM_CAPTURE-1:0] capture_irq_set;
  logic [6:0]             irq_set;
  logic [6:0]             irq_clear;
  logic [31:0]            rd_value;

  // ------------------------------------------------------------------
  // Bus decode. The slave never inserts wait states.
  // ------------------------------------------------------------------
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;
  assign addr_phase = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
  assign rd_take    = addr_phase & ~hwrite;
  assign rd_addr    = haddr[7:0];

  assign wr_irq = wr_pending_reg & (wr_addr_reg == OFS_IRQ_FLAGS);
  assign wr_ctrl   = wr_pending_reg & (wr_addr_reg == OFS_TIMER_CONTROL);
  assign wr_count  = wr_pending_reg & (wr_addr_reg == OFS_TIMER_COUNT);
  assign wr_pr     = wr_pending_reg & (wr_addr_reg == OFS_PRESCALE_MAX);
  assign wr_pcount = wr_pending_reg & (wr_addr_reg == OFS_PRESCALE_CNT);
  assign wr_act    = wr_pending_reg & (wr_addr_reg == OFS_MATCH_CTRL);
  assign wr_edge   = wr_pending_reg & (wr_addr_reg == OFS_CAPTURE_CTRL);
  assign wr_src = wr_pending_reg & (wr_addr_reg == OFS_CAPTURE_SRC);

  // ------------------------------------------------------------------
  // Match compare and actions.
  // ------------------------------------------------------------------
  assign counter_enable = timer_control_reg[CTRL_ENABLE_BIT];
  assign counter_reset  = timer_control_reg[CTRL_RESET_BIT];
  assign prescale_tick  = counter_enable & ~counter_reset &
                          (prescale_count_reg == prescale_max_reg);

  genvar m;
  generate
    for (m = 0; m < NUM_MATCH; m++) begin : g_match
      localparam int unsigned B = m * ACT_BITS_PER_CH;
      assign wr_match[m]  = wr_pending_reg &
                            (wr_addr_reg == OFS_MATCH_VALUE_0 + 8'(4 * m));
      assign wr_shadow[m] = wr_pending_reg &
                            (wr_addr_reg == OFS_SHADOW_0 + 8'(4 * m));
      // Equality is checked every cycle, independent of software.
      assign match_hit[m] = (match_value_reg[m] == timer_count_reg);
      // Only the first cycle of an equality counts as a new event.
      assign match_new[m] = match_hit[m] & ~match_prev_reg[m];
      assign match_irq_set[m] = match_new[m] &
        match_action_control_reg[B + ACT_IRQ_OFS];
      // The count clears on the increment that would leave the match.
      assign match_reset_req[m] = match_hit[m] & counter_enable &
        ~counter_reset & match_action_control_reg[B + ACT_RESET_OFS];
      assign match_stop_req[m] = match_hit[m] & counter_enable &
        ~counter_reset & match_action_control_reg[B + ACT_STOP_OFS];
      assign reload_enable[m] = match_action_control_reg[ACT_RELOAD_LSB + m];

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          match_value_reg[m]  <= COUNT_WIDTH'(REG_RESET_VALUE);
          shadow_value_reg[m] <= COUNT_WIDTH'(REG_RESET_VALUE);
        end else begin
          // A reload beats a software write landing in the same cycle.
          if (count_clear && reload_enable[m]) begin
            match_value_reg[m] <= shadow_value_reg[m];
          end else if (wr_match[m]) begin
            match_value_reg[m] <= hwdata[COUNT_WIDTH-1:0];
          end
          if (wr_shadow[m]) begin
            shadow_value_reg[m] <= hwdata[COUNT_WIDTH-1:0];
          end
        end
      end
    end
  endgenerate

  assign any_stop  = |match_stop_req;
  // A stop on the matching cycle still lets a reset clear the count.
  assign any_reset = |match_reset_req & (prescale_tick | any_stop);
  // Both paths that clear the count, the reset bit and a reset match, also drive the reloads.
  assign count_clear = counter_reset | any_reset;

  // ------------------------------------------------------------------
  // Capture channels.
  // ------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NUM_CAPTURE; c++) begin : g_capture
      localparam int unsigned B = c * EDGE_BITS_PER_CH;
      capture_edge_detect u_edge (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .pin_in        (capture_pin[c]),
        .internal_in   (capture_internal[c]),
        .use_internal  (capture_source_reg[c]),
        .rise_enable   (capture_edge_control_reg[B + EDGE_RISE_OFS]),
        .fall_enable   (capture_edge_control_reg[B + EDGE_FALL_OFS]),
        .capture_event (capture_event[c])
      );
      assign capture_irq_set[c] = capture_event[c] &
        capture_edge_control_reg[B + EDGE_IRQ_OFS];

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          captured_count_reg[c] <= COUNT_WIDTH'(REG_RESET_VALUE);
        end else if (capture_event[c]) begin
          captured_count_reg[c] <= timer_count_reg;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Interrupt flags: write one to clear; a new event wins the clear.
  // ------------------------------------------------------------------
  assign irq_set   = {capture_irq_set, match_irq_set};
  assign irq_clear = wr_irq ? hwdata[6:0] : 7'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flags_reg  <= 7'h00;
      match_prev_reg <= '0;
    end else begin
      irq_flags_reg  <= (irq_flags_reg & ~irq_clear) | irq_set;
      match_prev_reg <= match_hit;
    end
  end

  // ------------------------------------------------------------------
  // Timer control, timer count and prescaler.
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_control_reg <= 2'h0;
    end else if (any_stop) begin
      // A stopping match takes priority over a concurrent enable write.
      timer_control_reg[CTRL_ENABLE_BIT] <= 1'b0;
      if (wr_ctrl) begin
        timer_control_reg[CTRL_RESET_BIT] <= hwdata[CTRL_RESET_BIT];
      end
    end else if (wr_ctrl) begin
      timer_control_reg <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count_reg    <= COUNT_WIDTH'(REG_RESET_VALUE);
      prescale_count_reg <= COUNT_WIDTH'(REG_RESET_VALUE);
    end else if (count_clear) begin
      // Held at zero for as long as the reset bit stays set.
      timer_count_reg    <= '0;
      prescale_count_reg <= '0;
    end else if (any_stop) begin
      timer_count_reg    <= timer_count_reg;
      prescale_count_reg <= prescale_count_reg;
    end else if (wr_count || wr_pcount) begin
      if (wr_count) begin
        timer_count_reg <= hwdata[COUNT_WIDTH-1:0];
      end
      if (wr_pcount) begin
        prescale_count_reg <= hwdata[COUNT_WIDTH-1:0];
      end
    end else if (prescale_tick) begin
      timer_count_reg    <= timer_count_reg + 1'b1;
      prescale_count_reg <= '0;
    end else if (counter_enable) begin
      prescale_count_reg <= prescale_count_reg + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Plain configuration registers.
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_max_reg         <= COUNT_WIDTH'(REG_RESET_VALUE);
      match_action_control_reg <= REG_RESET_VALUE;
      capture_edge_control_reg <= 9'h000;
      capture_source_reg       <= '0;
    end else begin
      if (wr_pr) begin
        prescale_max_reg <= hwdata[COUNT_WIDTH-1:0];
      end
      // Reserved bits are not stored and read back as zero.
      if (wr_act) begin
        match_action_control_reg <= hwdata & ACT_WRITE_MASK;
      end
      if (wr_edge) begin
        capture_edge_control_reg <= hwdata[8:0];
      end
      if (wr_src) begin
        capture_source_reg <= hwdata[NUM_CAPTURE-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read mux and bus pipeline. Read data is sampled in the address
  // phase, so a register changing in the data phase shows its old value.
  // ------------------------------------------------------------------
  always_comb begin
    rd_value = 32'h0000_0000;
    case (rd_addr)
      OFS_IRQ_FLAGS:     rd_value = {25'h0, irq_flags_reg};
      OFS_TIMER_CONTROL: rd_value = {30'h0, timer_control_reg};
      OFS_TIMER_COUNT:   rd_value = 32'(timer_count_reg);
      OFS_PRESCALE_MAX:  rd_value = 32'(prescale_max_reg);
      OFS_PRESCALE_CNT:  rd_value = 32'(prescale_count_reg);
      OFS_MATCH_CTRL:    rd_value = match_action_control_reg;
      OFS_CAPTURE_CTRL:  rd_value = {23'h0, capture_edge_control_reg};
      OFS_CAPTURE_SRC:   rd_value = 32'(capture_source_reg);
      default: begin
        for (int i = 0; i < NUM_MATCH; i++) begin
          if (rd_addr == OFS_MATCH_VALUE_0 + 8'(4 * i)) begin
            rd_value = 32'(match_value_reg[i]);
          end
          if (rd_addr == OFS_SHADOW_0 + 8'(4 * i)) begin
            rd_value = 32'(shadow_value_reg[i]);
          end
        end
        for (int i = 0; i < NUM_CAPTURE; i++) begin
          if (rd_addr == OFS_CAPTURED_0 + 8'(4 * i)) begin
            rd_value = 32'(captured_count_reg[i]);
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending_reg <= 1'b0;
      wr_addr_reg    <= 8'h00;
      hrdata_reg     <= 32'h0000_0000;
    end else begin
      wr_pending_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (rd_take) begin
        hrdata_reg <= rd_value;
      end
    end
  end

endmodule : timer_match_capture_unit

// File: tb/timer_match_capture_properties.sv
// Bus-side assertions for the match and capture unit.
`timescale 1ns/100ps
module timer_match_capture_properties #(
  parameter int unsigned COUNT_WIDTH = 32
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Capture inputs
  input wire logic [timer_match_capture_pkg::NUM_CAPTURE-1:0] capture_pin,
  input wire logic [timer_match_capture_pkg::NUM_CAPTURE-1:0] capture_internal
);
  import timer_match_capture_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_take = hsel & hready & htrans[1] & !hwrite;
  sequence rd_at(logic [7:0] ofs);
    rd_take && haddr[7:0] == ofs;
  endsequence
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("ready dropped");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response");
  a_unmapped_zero: assert property (rd_at(8'h38) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_action_reserved: assert property (
    rd_at(OFS_MATCH_CTRL) |=> (hrdata & ~ACT_WRITE_MASK) == 32'h0)
    else $error("match control reserved bits set");
  a_edge_reserved: assert property (
    rd_at(OFS_CAPTURE_CTRL) |=> hrdata[31:9] == 23'h0)
    else $error("capture control reserved bits set");
  a_flags_reserved: assert property (
    rd_at(OFS_IRQ_FLAGS) |=> hrdata[31:7] == 25'h0)
    else $error("flag reserved bits set");
  a_control_reserved: assert property (
    rd_at(OFS_TIMER_CONTROL) |=> hrdata[31:2] == 30'h0)
    else $error("timer control reserved bits set");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_reset_rdata: assert property ($rose(hresetn) |-> hrdata == 32'h0)
    else $error("read data not zero after reset");
endmodule : timer_match_capture_properties

bind timer_match_capture_unit timer_match_capture_properties #(
  .COUNT_WIDTH(COUNT_WIDTH)
) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .capture_pin(capture_pin),
  .capture_internal(capture_internal)
);

// File: tb/capture_source.sv
// Behavioural source of the capture signals, pin and internal.
`timescale 1ns/100ps
module capture_source (
  // Clock
  input  wire logic                                    hclk,
  // Capture signals
  output logic [timer_match_capture_pkg::NUM_CAPTURE-1:0] src_pin,
  output logic [timer_match_capture_pkg::NUM_CAPTURE-1:0] src_int
);
  import timer_match_capture_pkg::*;
  initial begin
    src_pin = '0;
    src_int = '0;
  end
  // Each level is held for several clocks, since the synchroniser and the
  // edge compare need it stable; a shorter pulse could be lost.
  task automatic drive(input int ch, input logic internal, input logic lvl);
    @(posedge hclk);
    if (internal) src_int[ch] <= lvl;
    else src_pin[ch] <= lvl;
    repeat (5) @(posedge hclk);
  endtask : drive
endmodule : capture_source

// File: tb/timer_match_capture_unit_tb.sv
// Self-checking bench for the match and capture unit.
`timescale 1ns/100ps
module timer_match_capture_unit_tb;
  import timer_match_capture_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [NUM_CAPTURE-1:0] src_pin;
  logic [NUM_CAPTURE-1:0] src_int;
  logic [31:0] rd;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;

  always #25 hclk = ~hclk;

  timer_match_capture_unit dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .capture_pin(src_pin), .capture_internal(src_int)
  );
  capture_source src_u (.hclk(hclk), .src_pin(src_pin), .src_int(src_int));

  task automatic finish_test;
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(n, rd, exp);
  endtask : rdc

  function automatic logic [31:0] action_bits(input int ch, input logic irq,
                                           input logic rst, input logic stp);
    return 32'({stp, rst, irq}) << (3 * ch);
  endfunction : action_bits

  function automatic logic [31:0] capture_expect(input int mode,
      input logic [31:0] prev, input logic [31:0] at_rise, at_fall);
    if (mode[1]) return at_fall;
    if (mode[0]) return at_rise;
    return prev;
  endfunction : capture_expect

  initial begin
    logic [31:0] m, s, k, vb, vc, ex;
    logic [31:0] prev [NUM_CAPTURE];
    logic        irq, isel;
    logic [7:0]  ca;
    void'($urandom(32'h92e7041b));
    prev = '{default: 32'h0};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 'h14; a <= 'h38; a += 4)
      rdc("reset value", 8'(a), 32'h0);
    wr(8'h38, $urandom);
    rdc("unmapped", 8'h38, 32'h0);
    wr(OFS_CAPTURED_0, $urandom);
    rdc("captured_count_0", OFS_CAPTURED_0, 32'h0);
    for (int n = 0; n < 4; n++) begin
      m = $urandom;
      wr(OFS_MATCH_VALUE_0 + 8'(4 * n), m);
      rdc("match_value", OFS_MATCH_VALUE_0 + 8'(4 * n), m);
    end
    // Channel 0 flags and resets with reload, 1 flags only, 2 and 3 take no action.
    m = 6 + $urandom_range(6);
    s = 4 + $urandom_range(1);
    wr(OFS_MATCH_VALUE_0, m);
    wr(OFS_MATCH_VALUE_0 + 8'h4, 32'h2);
    wr(OFS_MATCH_VALUE_0 + 8'h8, 32'h3);
    wr(OFS_SHADOW_0, s);
    wr(OFS_MATCH_CTRL, action_bits(0, 1, 1, 0) | action_bits(1, 1, 0, 0)
       | 32'h0100_0000);
    wr(OFS_TIMER_CONTROL, 32'h1);
    repeat (30) @(posedge hclk);
    wr(OFS_TIMER_CONTROL, 32'h0);
    rdc("match_value_0", OFS_MATCH_VALUE_0, s);
    rdc("flags", OFS_IRQ_FLAGS, 32'h3);
    xfer(1'b0, OFS_TIMER_COUNT, 32'h0);
    check("count in period", 32'(rd <= s), 32'h1);
    wr(OFS_IRQ_FLAGS, 32'h7F);
    rdc("flags", OFS_IRQ_FLAGS, 32'h0);
    s = $urandom_range(200, 100);
    wr(OFS_SHADOW_0, s);
    wr(OFS_TIMER_CONTROL, 32'h2);
    rdc("timer_count", OFS_TIMER_COUNT, 32'h0);
    wr(OFS_TIMER_CONTROL, 32'h0);
    rdc("match_value_0", OFS_MATCH_VALUE_0, s);
    k = 5 + $urandom_range(10);
    wr(OFS_MATCH_CTRL, action_bits(3, 0, 0, 1));
    wr(OFS_MATCH_VALUE_3, k);
    wr(OFS_TIMER_CONTROL, 32'h1);
    repeat (40) @(posedge hclk);
    rdc("timer_control", OFS_TIMER_CONTROL, 32'h0);
    rdc("timer_count", OFS_TIMER_COUNT, k);
    wr(OFS_TIMER_CONTROL, 32'h2);
    wr(OFS_TIMER_CONTROL, 32'h0);
    wr(OFS_MATCH_VALUE_3, k);
    wr(OFS_SHADOW_3, k + 3);
    wr(OFS_MATCH_CTRL, action_bits(3, 0, 1, 1) | 32'h0800_0000);
    wr(OFS_TIMER_CONTROL, 32'h1);
    repeat (40) @(posedge hclk);
    rdc("timer_control", OFS_TIMER_CONTROL, 32'h0);
    rdc("timer_count", OFS_TIMER_COUNT, 32'h0);
    rdc("match_value_3", OFS_MATCH_VALUE_3, k + 3);
    wr(OFS_MATCH_CTRL, 32'h0);
    for (int c = 0; c < 3; c++)
      for (int mode = 1; mode < 4; mode++) begin
        irq = 1'($urandom_range(1));
        isel = 1'($urandom_range(1));
        wr(OFS_IRQ_FLAGS, 32'h7F);
        wr(OFS_CAPTURE_SRC, 32'(isel) << c);
        wr(OFS_CAPTURE_CTRL,
           32'({irq, mode[1:0]}) << (3 * c));
        wr(OFS_TIMER_COUNT, $urandom);
        src_u.drive(c, !isel, 1'b1);
        src_u.drive(c, !isel, 1'b0);
        vb = $urandom;
        wr(OFS_TIMER_COUNT, vb);
        src_u.drive(c, isel, 1'b1);
        vc = $urandom;
        wr(OFS_TIMER_COUNT, vc);
        src_u.drive(c, isel, 1'b0);
        ex = capture_expect(mode, prev[c], vb, vc);
        ca = OFS_CAPTURED_0 + 8'(4 * c);
        rdc("captured", ca, ex);
        rdc("flags", OFS_IRQ_FLAGS, 32'(irq) << (4+c));
        prev[c] = ex;
      end
    finish_test();
  end
endmodule : timer_match_capture_unit_tb
